// ==== logic/sfc_freq_ctrl.sv ====
// Frequency-word generation and delta-sigma modulator for the synthesizer
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RL1: Third-order modulator, 10 MHz, modulo 64000
// RL2: Integer ratio is band field plus 24
// RL3: Band integer writes above 23 clamp
// RL4: Band select 1 undivided, 0 halved
// RL5: Fraction combines carrier, offset and deviation
// RL6: Programmed frequency is channel centre
// RL7: Receive lowers synthesizer by 937.5 kHz
// RL8: Hop step counts 10 kHz units
// RL9: Carrier adds step times channel times 10k
// RL10: Host hops by writing channel or step
// RL11: Hop write in TX/RX retunes, defers packet
// RL12: Offset field is signed ten-bit
// RL13: Deviation steps 625 Hz regardless of band
// RL14: New values apply on next modulator tick
module sfc_freq_ctrl #(
  parameter int TUNE_CYCLES = sfc_pkg::TUNE_CYCLES
) (
  input  wire logic                  clk_in,
  input  wire logic                  reset_n_in,
  input  wire sfc_pkg::sfc_reg_req_s reg_req_in,
  output logic [7:0]                 reg_rdata_out,
  input  wire logic                  tx_mode_in,
  input  wire logic                  rx_mode_in,
  input  wire logic                  tx_packet_active_in,
  input  wire logic                  tx_data_in,
  input  wire logic [8:0]            deviation_field_in,
  output sfc_pkg::sfc_synth_s        synth_out,
  output logic                       tune_active_out
);
  import sfc_pkg::*;

  // ==========================================================
  // Host registers
  logic [7:0] offset_low_reg, offset_low_next;
  logic [1:0] offset_high_reg, offset_high_next;
  logic [6:0] band_reg, band_next;
  logic [7:0] frac_high_reg, frac_high_next;
  logic [7:0] frac_low_reg, frac_low_next;
  logic [7:0] hop_ch_reg, hop_ch_next;
  logic [7:0] hop_step_reg, hop_step_next;
  logic [7:0] rdata_reg, rdata_next;

  always_comb begin
    offset_low_next  = offset_low_reg;
    offset_high_next = offset_high_reg;
    band_next        = band_reg;
    frac_high_next   = frac_high_reg;
    frac_low_next    = frac_low_reg;
    hop_ch_next      = hop_ch_reg;
    hop_step_next    = hop_step_reg;
    rdata_next       = rdata_reg;
    if (reg_req_in.write) begin
      if (reg_req_in.addr == OFF_FREQ_OFFSET_LOW) begin
        offset_low_next = reg_req_in.data;
      end else if (reg_req_in.addr == OFF_FREQ_OFFSET_HIGH) begin
        offset_high_next = reg_req_in.data[1:0] & OFFSET_HIGH_MASK_W;
      end else if (reg_req_in.addr == OFF_BAND_SELECT) begin
        band_next = reg_req_in.data[6:0];
        // RL3: clamp band integer
        if (reg_req_in.data[BS_INT_MSB:0] > BAND_INT_MAX) begin
          band_next[BS_INT_MSB:0] = BAND_INT_MAX;
        end
      end else if (reg_req_in.addr == OFF_CARRIER_FRAC_HIGH) begin
        frac_high_next = reg_req_in.data;
      end else if (reg_req_in.addr == OFF_CARRIER_FRAC_LOW) begin
        frac_low_next = reg_req_in.data;
      end else if (reg_req_in.addr == OFF_HOP_CHANNEL) begin
        hop_ch_next = reg_req_in.data;
      end else if (reg_req_in.addr == OFF_HOP_STEP) begin
        hop_step_next = reg_req_in.data;
      end
    end
    if (reg_req_in.read) begin
      if (reg_req_in.addr == OFF_FREQ_OFFSET_LOW) begin
        rdata_next = offset_low_reg;
      end else if (reg_req_in.addr == OFF_FREQ_OFFSET_HIGH) begin
        rdata_next = {6'h00, offset_high_reg};
      end else if (reg_req_in.addr == OFF_BAND_SELECT) begin
        rdata_next = {1'b0, band_reg};
      end else if (reg_req_in.addr == OFF_CARRIER_FRAC_HIGH) begin
        rdata_next = frac_high_reg;
      end else if (reg_req_in.addr == OFF_CARRIER_FRAC_LOW) begin
        rdata_next = frac_low_reg;
      end else if (reg_req_in.addr == OFF_HOP_CHANNEL) begin
        rdata_next = hop_ch_reg;
      end else if (reg_req_in.addr == OFF_HOP_STEP) begin
        rdata_next = hop_step_reg;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      offset_low_reg  <= RST_FREQ_OFFSET_LOW;
      offset_high_reg <= RST_FREQ_OFFSET_HIGH[1:0];
      band_reg        <= RST_BAND_SELECT[6:0];
      frac_high_reg   <= RST_CARRIER_FRAC_HIGH;
      frac_low_reg    <= RST_CARRIER_FRAC_LOW;
      hop_ch_reg      <= RST_HOP_CHANNEL;
      hop_step_reg    <= RST_HOP_STEP;
      rdata_reg       <= 8'h00;
    end else begin
      offset_low_reg  <= offset_low_next;
      offset_high_reg <= offset_high_next;
      band_reg        <= band_next;
      frac_high_reg   <= frac_high_next;
      frac_low_reg    <= frac_low_next;
      hop_ch_reg      <= hop_ch_next;
      hop_step_reg    <= hop_step_next;
      rdata_reg       <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;

  // ==========================================================
  // Reference tick and hop sequencing
  logic [4:0]  tick_cnt_reg, tick_cnt_next;
  logic        tick;
  sfc_state_e  state_reg, state_next;
  logic [31:0] tune_cnt_reg, tune_cnt_next;
  logic        hop_pend_reg, hop_pend_next;
  logic [7:0]  hop_ch_app_reg, hop_ch_app_next;
  logic [7:0]  hop_step_app_reg, hop_step_app_next;
  logic        hop_write;

  assign tick      = (tick_cnt_reg == 5'(TICK_DIV - 1));
  assign hop_write = reg_req_in.write && (reg_req_in.addr == OFF_HOP_CHANNEL
                     || reg_req_in.addr == OFF_HOP_STEP);

  always_comb begin
    tick_cnt_next     = tick ? 5'h00 : tick_cnt_reg + 5'h01;
    state_next        = state_reg;
    tune_cnt_next     = tune_cnt_reg;
    hop_pend_next     = hop_pend_reg;
    hop_ch_app_next   = hop_ch_app_reg;
    hop_step_app_next = hop_step_app_reg;
    case (state_reg)
      ST_RUN: begin
        if (hop_pend_reg) begin
          if (!tx_mode_in && !rx_mode_in) begin
            hop_ch_app_next   = hop_ch_reg;
            hop_step_app_next = hop_step_reg;
            hop_pend_next     = 1'b0;
          end else if (tx_mode_in && tx_packet_active_in) begin
            // RL11: defer to packet end
            state_next = ST_DEFER;
          end else begin
            // RL11: retune in place
            state_next        = ST_TUNE;
            tune_cnt_next     = 32'h0000_0000;
            hop_ch_app_next   = hop_ch_reg;
            hop_step_app_next = hop_step_reg;
            hop_pend_next     = 1'b0;
          end
        end
      end
      ST_DEFER: begin
        if (!(tx_mode_in && tx_packet_active_in)) begin
          state_next = ST_RUN;
        end
      end
      ST_TUNE: begin
        tune_cnt_next = tune_cnt_reg + 32'h0000_0001;
        if (tune_cnt_reg == 32'(TUNE_CYCLES - 1)) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
    // Set wins over clear
    if (hop_write) begin
      hop_pend_next = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      tick_cnt_reg     <= 5'h00;
      state_reg        <= ST_RUN;
      tune_cnt_reg     <= 32'h0000_0000;
      hop_pend_reg     <= 1'b0;
      hop_ch_app_reg   <= RST_HOP_CHANNEL;
      hop_step_app_reg <= RST_HOP_STEP;
    end else begin
      tick_cnt_reg     <= tick_cnt_next;
      state_reg        <= state_next;
      tune_cnt_reg     <= tune_cnt_next;
      hop_pend_reg     <= hop_pend_next;
      hop_ch_app_reg   <= hop_ch_app_next;
      hop_step_app_reg <= hop_step_app_next;
    end
  end

  assign tune_active_out = (state_reg == ST_TUNE);

  // ==========================================================
  // Frequency word and third-order modulator
  logic               hb;
  logic signed [26:0] base_w, hop_w, off_w, dev_w, rx_w, total_w;
  logic [25:0]        total_u;
  logic [7:0]         int_w;
  logic [15:0]        frac_w;
  logic [15:0]        acc1_reg, acc1_next, acc2_reg, acc2_next;
  logic [15:0]        acc3_reg, acc3_next, acc1_new, acc2_new, acc3_new;
  logic               c2d_reg, c3d_reg, c3dd_reg;
  logic               c1, c2, c3, c2d_next, c3d_next, c3dd_next;
  logic [16:0]        s1, s2, s3;
  logic signed [9:0]  mod_y;
  sfc_synth_s         synth_reg, synth_next;
  assign hb = band_reg[BS_HIGH_BIT];

  always_comb begin
    // RL2: integer plus 24, fraction over 64000
    base_w  = 27'(({20'h0_0000, 2'b00, band_reg[4:0]} + 27'(INT_BASE))
                  * 27'(FRAC_MODULUS)) + 27'({frac_high_reg, frac_low_reg});
    // RL8: step units of 10 kHz
    // RL9: step times channel added
    hop_w   = 27'(((27'(hop_step_app_reg) * 27'(hop_ch_app_reg))
                   << HOP_UNIT_SHL) >> hb);
    // RL12: signed offset
    off_w   = 27'(signed'({offset_high_reg, offset_low_reg}));
    // RL13: 625 Hz steps in any band
    dev_w   = 27'(({18'h0_0000, deviation_field_in} << DEV_UNIT_SHL) >> hb);
    // RL5: fraction terms, FSK in loop
    if (!tx_mode_in) begin
      dev_w = 27'h000_0000;
    end else if (!tx_data_in) begin
      dev_w = -dev_w;
    end
    // RL7: receive down-shift
    // RL6: word is channel centre
    rx_w    = rx_mode_in ? 27'(RX_SHIFT_UNIT >> hb) : 27'h000_0000;
    total_w = base_w + hop_w + off_w + dev_w - rx_w;
    total_u = total_w[26] ? 26'h000_0000 : total_w[25:0];
    int_w   = 8'(total_u / FRAC_MODULUS);
    frac_w  = 16'(total_u % FRAC_MODULUS);
  end

  always_comb begin
    // RL1: modulo-64000 accumulators
    s1 = {1'b0, acc1_reg} + {1'b0, synth_reg.frac_word};
    c1 = (s1 >= 17'(FRAC_MODULUS));
    acc1_new = c1 ? 16'(s1 - 17'(FRAC_MODULUS)) : s1[15:0];
    s2 = {1'b0, acc2_reg} + {1'b0, acc1_new};
    c2 = (s2 >= 17'(FRAC_MODULUS));
    acc2_new = c2 ? 16'(s2 - 17'(FRAC_MODULUS)) : s2[15:0];
    s3 = {1'b0, acc3_reg} + {1'b0, acc2_new};
    c3 = (s3 >= 17'(FRAC_MODULUS));
    acc3_new = c3 ? 16'(s3 - 17'(FRAC_MODULUS)) : s3[15:0];
    acc1_next = tick ? acc1_new : acc1_reg;
    acc2_next = tick ? acc2_new : acc2_reg;
    acc3_next = tick ? acc3_new : acc3_reg;
    c2d_next  = tick ? c2 : c2d_reg;
    c3d_next  = tick ? c3 : c3d_reg;
    c3dd_next = tick ? c3d_reg : c3dd_reg;
    mod_y = 10'(c1) + 10'(c2) - 10'(c2d_reg) + 10'(c3)
            - 10'({c3d_reg, 1'b0}) + 10'(c3dd_reg);
    synth_next = synth_reg;
    // RL14: apply on modulator tick
    if (tick) begin
      synth_next.int_ratio  = int_w;
      synth_next.frac_word  = frac_w;
      synth_next.div_ratio  = 9'(10'({2'b00, synth_reg.int_ratio}) + mod_y);
      // RL4: divide-by-two outside loop
      synth_next.band_halve = !hb;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      acc1_reg  <= 16'h0000;
      acc2_reg  <= 16'h0000;
      acc3_reg  <= 16'h0000;
      c2d_reg   <= 1'b0;
      c3d_reg   <= 1'b0;
      c3dd_reg  <= 1'b0;
      synth_reg <= '0;
    end else begin
      acc1_reg  <= acc1_next;
      acc2_reg  <= acc2_next;
      acc3_reg  <= acc3_next;
      c2d_reg   <= c2d_next;
      c3d_reg   <= c3d_next;
      c3dd_reg  <= c3dd_next;
      synth_reg <= synth_next;
    end
  end

  assign synth_out = synth_reg;
endmodule
`default_nettype wire

// ==== shared/sfc_pkg.sv ====
// Package for the synthesizer frequency-control block
package sfc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [6:0] OFF_FREQ_OFFSET_LOW   = 7'h73;
  localparam logic [6:0] OFF_FREQ_OFFSET_HIGH  = 7'h74;
  localparam logic [6:0] OFF_BAND_SELECT       = 7'h75;
  localparam logic [6:0] OFF_CARRIER_FRAC_HIGH = 7'h76;
  localparam logic [6:0] OFF_CARRIER_FRAC_LOW  = 7'h77;
  localparam logic [6:0] OFF_HOP_CHANNEL       = 7'h79;
  localparam logic [6:0] OFF_HOP_STEP          = 7'h7a;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_FREQ_OFFSET_LOW   = 8'h00;
  localparam logic [7:0] RST_FREQ_OFFSET_HIGH  = 8'h00;
  localparam logic [7:0] RST_BAND_SELECT       = 8'h35;
  localparam logic [7:0] RST_CARRIER_FRAC_HIGH = 8'hbb;
  localparam logic [7:0] RST_CARRIER_FRAC_LOW  = 8'h80;
  localparam logic [7:0] RST_HOP_CHANNEL       = 8'h00;
  localparam logic [7:0] RST_HOP_STEP          = 8'h00;

  // ==========================================================
  // Field layout of band_select
  localparam int BS_SIDE_BIT = 6;
  localparam int BS_HIGH_BIT = 5;
  localparam int BS_INT_MSB  = 4;
  localparam logic [4:0] BAND_INT_MAX = 5'h17;
  localparam logic [1:0] OFFSET_HIGH_MASK_W = 2'h3;

  // ==========================================================
  // Synthesizer arithmetic
  localparam logic [6:0]  INT_BASE      = 7'h18;
  localparam logic [25:0] FRAC_MODULUS  = 26'h0_FA00;
  localparam logic [25:0] RX_SHIFT_UNIT = 26'h0_1770;
  localparam int          HOP_UNIT_SHL  = 6;
  localparam int          DEV_UNIT_SHL  = 2;

  // ==========================================================
  // Timing
  localparam longint CLK_HZ       = 200_000_000;
  localparam longint REF_HZ       = 10_000_000;
  localparam int     TICK_DIV     = int'(CLK_HZ / REF_HZ);
  localparam int     TUNE_TIME_NS = 200_000;
  localparam int     TUNE_CYCLES  = int'((longint'(TUNE_TIME_NS) * CLK_HZ
                                         + 999_999_999) / 1_000_000_000);

  // ==========================================================
  // Types
  typedef enum logic [1:0] {ST_RUN, ST_DEFER, ST_TUNE} sfc_state_e;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [6:0] addr;
    logic [7:0] data;
  } sfc_reg_req_s;

  typedef struct packed {
    logic [7:0]  int_ratio;
    logic [15:0] frac_word;
    logic [8:0]  div_ratio;
    logic        band_halve;
  } sfc_synth_s;
endpackage

// ==== verification/sfc_freq_ctrl_monitor.sv ====
// Port checker for the synthesizer frequency-control block
`timescale 1ns/1ps
`default_nettype none
module sfc_freq_ctrl_monitor #(
  parameter int TUNE_CYCLES = sfc_pkg::TUNE_CYCLES
) (
  input wire logic                  clk_in,
  input wire logic                  reset_n_in,
  input wire sfc_pkg::sfc_reg_req_s reg_req_in,
  input wire logic [7:0]            reg_rdata_out,
  input wire logic                  tx_mode_in,
  input wire logic                  rx_mode_in,
  input wire logic                  tx_packet_active_in,
  input wire sfc_pkg::sfc_synth_s   synth_out,
  input wire logic                  tune_active_out
);
  import sfc_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // ==========================================================
  // Tick and tune counters
  logic [4:0]  tick_reg, tick_next;
  logic [31:0] tune_reg, tune_next;
  always_comb begin
    tick_next = (tick_reg == 5'h13) ? 5'h00 : tick_reg + 5'h01;
    tune_next = tune_active_out ? tune_reg + 32'h0000_0001 : 32'h0000_0000;
    if (!reset_n_in) begin
      tick_next = 5'h00;
      tune_next = 32'h0000_0000;
    end
  end
  always_ff @(posedge clk_in) begin
    tick_reg <= tick_next;
    tune_reg <= tune_next;
  end
  // ==========================================================
  // Assertions
  synth_hold_a: assert property (
    tick_reg != 5'h13 |=> $stable(synth_out)) else $error("synth moved");
  frac_range_a: assert property (
    synth_out.frac_word < 16'hfa00) else $error("fraction too big");
  tune_length_a: assert property (
    $fell(tune_active_out) |-> tune_reg == TUNE_CYCLES)
    else $error("tune length wrong");
  tune_mode_a: assert property (
    $rose(tune_active_out) |-> $past(tx_mode_in || rx_mode_in))
    else $error("tune while idle");
  tune_defer_a: assert property (
    $rose(tune_active_out) |-> !$past(tx_mode_in && tx_packet_active_in))
    else $error("tune inside packet");
  band_clamp_a: assert property (
    reg_req_in.read && reg_req_in.addr == OFF_BAND_SELECT |-> ##1
    (reg_rdata_out[4:0] <= BAND_INT_MAX && !reg_rdata_out[7]))
    else $error("band field not clamped");
  offset_read_a: assert property (
    reg_req_in.read && reg_req_in.addr == OFF_FREQ_OFFSET_HIGH |-> ##1
    reg_rdata_out[7:2] == 6'h00) else $error("offset high bits set");
  band_halve_a: assert property (
    reg_req_in.write && reg_req_in.addr == OFF_BAND_SELECT |-> ##22
    synth_out.band_halve == !$past(reg_req_in.data[5], 22))
    else $error("band halve wrong");
  tune_seen_c: cover property ($rose(tune_active_out));
  band_write_c: cover property (reg_req_in.write && reg_req_in.addr == 7'h75);
  rx_seen_c: cover property (rx_mode_in && tune_active_out);
endmodule
bind sfc_freq_ctrl sfc_freq_ctrl_monitor #(.TUNE_CYCLES(TUNE_CYCLES)) mon_u (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_req_in(reg_req_in),
  .reg_rdata_out(reg_rdata_out), .tx_mode_in(tx_mode_in),
  .rx_mode_in(rx_mode_in), .tx_packet_active_in(tx_packet_active_in),
  .synth_out(synth_out), .tune_active_out(tune_active_out));
`default_nettype wire

// ==== verification/sfc_freq_ctrl_tb.sv ====
// Testbench for the synthesizer frequency-control block
`timescale 1ns/1ps
`default_nettype none
module sfc_freq_ctrl_tb;
  import sfc_pkg::*;
  localparam int B = 47 * 64000 + 47999;
  logic         clk_in = 0, reset_n_in = 0, tx = 0, rx = 0, pkt = 0, txd = 0;
  logic [8:0]   dev = 9'h000;
  sfc_reg_req_s req;
  sfc_synth_s   synth;
  logic [7:0]   rdata, v;
  logic         tune;
  int           miscompares = 0, check_count = 0;
  logic [6:0]   offs[7] = '{OFF_FREQ_OFFSET_LOW, OFF_FREQ_OFFSET_HIGH,
    OFF_BAND_SELECT, OFF_CARRIER_FRAC_HIGH, OFF_CARRIER_FRAC_LOW,
    OFF_HOP_CHANNEL, OFF_HOP_STEP};
  logic [7:0]   rsts[7] = '{RST_FREQ_OFFSET_LOW, RST_FREQ_OFFSET_HIGH,
    RST_BAND_SELECT, RST_CARRIER_FRAC_HIGH, RST_CARRIER_FRAC_LOW,
    RST_HOP_CHANNEL, RST_HOP_STEP};
  always #2.5 clk_in = ~clk_in;
  sfc_freq_ctrl #(.TUNE_CYCLES(8)) dut_u (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .tx_mode_in(tx), .rx_mode_in(rx), .tx_packet_active_in(pkt),
    .tx_data_in(txd), .deviation_field_in(dev), .synth_out(synth),
    .tune_active_out(tune));
  sfc_host_model host_u (.clk_in(clk_in), .req_out(req), .rdata_in(rdata));
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    host_u.rd(a, v);
    check(32'(v), 32'(e), "register read");
  endtask
  task automatic wchk(input int w);
    int d;
    repeat (45) @(negedge clk_in);
    d = int'(synth.div_ratio) - int'(synth.int_ratio);
    check(32'(synth.int_ratio), 32'(w / 64000), "integer ratio");
    check(32'(synth.frac_word), 32'(w % 64000), "fraction word");
    check(32'(d >= -3 && d <= 4), 32'h0000_0001, "modulator range");
  endtask
  task automatic wait_tune;
    for (int n = 0; n < 100 && tune !== 1'b1; n++) @(negedge clk_in);
    check(32'(tune), 32'h0000_0001, "retune seen");
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #30000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up;
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (20) @(negedge clk_in);
    reset_n_in = 1;
    for (int i = 0; i < 7; i++) rchk(offs[i], rsts[i]);
    rchk(7'h78, 8'h00);
    wchk(45 * 64000 + 48000);
    $display("test reset done");
    host_u.wr(OFF_BAND_SELECT, 8'h3f);
    rchk(OFF_BAND_SELECT, 8'h37);
    wchk(B + 1);
    host_u.wr(OFF_FREQ_OFFSET_LOW, 8'hff);
    host_u.wr(OFF_FREQ_OFFSET_HIGH, 8'hff);
    rchk(OFF_FREQ_OFFSET_HIGH, 8'h03);
    wchk(B);
    $display("test clamp offset done");
    host_u.wr(OFF_HOP_STEP, 8'hff);
    host_u.hop(8'h05);
    rchk(OFF_HOP_CHANNEL, 8'h05);
    wchk(B + 255 * 5 * 32);
    host_u.wr(OFF_BAND_SELECT, 8'h17);
    wchk(B + 255 * 5 * 64);
    check(32'(synth.band_halve), 32'h0000_0001, "band halve");
    $display("test hop band done");
    rx = 1;
    wchk(B + 81600 - 6000);
    host_u.hop(8'h06);
    wait_tune;
    wchk(B + 97920 - 6000);
    $display("test receive done");
    rx = 0;
    tx = 1;
    pkt = 1;
    txd = 1;
    dev = 9'h00a;
    wchk(B + 97920 + 40);
    host_u.hop(8'h05);
    repeat (30) @(negedge clk_in);
    check(32'(tune), 32'h0000_0000, "deferred in packet");
    wchk(B + 97920 + 40);
    pkt = 0;
    wait_tune;
    wchk(B + 81600 + 40);
    txd = 0;
    wchk(B + 81600 - 40);
    $display("test transmit done");
    wrap_up;
  end
endmodule
`default_nettype wire

// ==== verification/sfc_host_model.sv ====
// Host model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model (
  input  wire logic             clk_in,
  output var sfc_pkg::sfc_reg_req_s req_out,
  input  wire logic [7:0]       rdata_in
);
  import sfc_pkg::*;
  initial req_out = '0;
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_in);
    req_out = '{write: 1'b1, read: 1'b0, addr: a, data: d};
    @(negedge clk_in);
    req_out = '0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk_in);
    req_out = '{write: 1'b0, read: 1'b1, addr: a, data: 8'h00};
    @(negedge clk_in);
    req_out = '0;
    @(negedge clk_in);
    d = rdata_in;
  endtask
  task automatic hop(input logic [7:0] ch);
    wr(OFF_HOP_CHANNEL, ch);
  endtask
endmodule
`default_nettype wire
